//--- core/slpm_consts.svh
/*
 * Constants of the link power manager: register map, field positions,
 * reset values and exit times.
 * Assumes inclusion by bare name from the package and the design modules.
 */
// Function
// - accept and acknowledge device Partial/Slumber requests
// - host wakes Partial/Slumber link with COMWAKE
// - Partial exit within 10 ns (code clamps the wake timeout to one hclk cycle, 100 ns)
// - Slumber exit within 10 ms
// - Device Sleep exit 20 ms unless overridden
// - Device Sleep only entered from Slumber
// - D1/D3 reached by standby command (code: D3 set by a power-state register write; D1 not decoded)
// - in D3 only power-state register accessible
// - no interrupts raised while in D3
// - in D3 ports treated as empty
// - D3 to D0 causes no reset
// - activity indicator low while any port busy
// - per-port present and enable bits
// - low power mode may miss device wake
// - per-port PHY dynamic power gating enable
// - three ports, each separately enableable
`ifndef SLPM_CONSTS_SVH
`define SLPM_CONSTS_SVH

`define SLPM_NPORT          3
`define SLPM_CLK_HZ         10000000
`define SLPM_PARTIAL_EXIT_NS 10
`define SLPM_SLUMBER_EXIT_MS 10
`define SLPM_DEVSLP_EXIT_MS 20

`define SLPM_ADDR_PCS       12'h000
`define SLPM_ADDR_PMCSR     12'h004
`define SLPM_ADDR_LPCTL     12'h008
`define SLPM_ADDR_LSTAT     12'h00C
`define SLPM_ADDR_DETO      12'h010
`define SLPM_ADDR_PHYGATE   12'h050

`define SLPM_PCS_EN_LSB     0
`define SLPM_PCS_PR_LSB     8
`define SLPM_LP_EN_BIT      0
`define SLPM_LP_DS_LSB      1
`define SLPM_LS_TMO_LSB     10
`define SLPM_LS_ABT_BIT     13
`define SLPM_LS_LED_BIT     14
`define SLPM_PWR_D0         2'h0
`define SLPM_PWR_D3         2'h3
`define SLPM_PCS_RST        3'h0
`define SLPM_DETO_RST       8'h00
`define SLPM_HTRANS_NSEQ    2'h2

`endif

//--- core/slpm_pkg.sv
/*
 * Types shared by the link power manager modules.
 * Assumes the constants header is on the include path.
 */
`include "slpm_consts.svh"
package slpm_pkg;
    // gray coded along off, active, partial, slumber, sleep, wake
    typedef enum logic [2:0] {
        LK_OFF     = 3'h0,
        LK_ACTIVE  = 3'h1,
        LK_PARTIAL = 3'h3,
        LK_SLUMBER = 3'h2,
        LK_DEVSLP  = 3'h6,
        LK_WAKE    = 3'h7
    } slpm_link_t;

    typedef enum logic [2:0] {
        RS_PCS, RS_PMCSR, RS_LPCTL, RS_LSTAT, RS_DETO, RS_PHYGATE, RS_NONE
    } slpm_reg_t;
endpackage

//--- core/slpm_port_link.sv
/*
 * Per-port link power state machine: Partial, Slumber, Device Sleep, wake.
 * Assumes synchronised device inputs and limits stable while waking.
 */
`timescale 1ns/1ps
`default_nettype none
`include "slpm_consts.svh"
module slpm_port_link
    import slpm_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        en,
    input  wire logic        present,
    input  wire logic        d3,
    input  wire logic        lp_en,
    input  wire logic        devslp_en,
    input  wire logic        gate_en,
    input  wire logic        op_req,
    input  wire logic        part_req,
    input  wire logic        slum_req,
    input  wire logic        wake_det,
    input  wire logic [23:0] slumber_lim,
    input  wire logic [23:0] devslp_lim,
    output var  slpm_link_t  state_q,
    output var  logic        ack_q,
    output var  logic        comwake_q,
    output var  logic        devslp_q,
    output var  logic        gate_q,
    output var  logic        pwrdn_q,
    output var  logic        tmo_q
);
    localparam int PART_RAW = (`SLPM_PARTIAL_EXIT_NS * (`SLPM_CLK_HZ / 1000000)) / 1000;
    localparam logic [23:0] PART_CYC = (PART_RAW < 1) ? 24'h000001 : 24'(PART_RAW);

    slpm_link_t  state_d;
    logic        pp_q, sp_q, ack_d, cw_d, tmo_d;
    logic [23:0] cnt_q, lim_q, lim_d;
    logic        part_rise, slum_rise;

    assign part_rise = part_req & ~pp_q;
    assign slum_rise = slum_req & ~sp_q;

    always_comb begin
        state_d = state_q;
        ack_d   = 1'b0;
        cw_d    = 1'b0;
        tmo_d   = 1'b0;
        lim_d   = lim_q;
        if (state_q != LK_OFF && (part_rise || slum_rise)) begin
            ack_d = 1'b1;
        end
        case (state_q)
            LK_OFF: begin
                if (en && present && !d3) begin
                    state_d = LK_ACTIVE;
                end
            end
            LK_ACTIVE: begin
                if (slum_rise) begin
                    state_d = LK_SLUMBER;
                end else if (part_rise) begin
                    state_d = LK_PARTIAL;
                end
            end
            LK_PARTIAL: begin
                if (op_req) begin
                    state_d = LK_WAKE;
                    cw_d    = 1'b1;
                    lim_d   = PART_CYC;
                end else if (wake_det) begin
                    state_d = LK_ACTIVE;
                end
            end
            LK_SLUMBER: begin
                if (op_req) begin
                    state_d = LK_WAKE;
                    cw_d    = 1'b1;
                    lim_d   = slumber_lim;
                end else if (wake_det && !lp_en) begin
                    state_d = LK_ACTIVE;
                end else if (devslp_en) begin
                    state_d = LK_DEVSLP;
                end
            end
            LK_DEVSLP: begin
                // sleep exit limit, device sends wake
                if (op_req) begin
                    state_d = LK_WAKE;
                    lim_d   = devslp_lim;
                end
            end
            LK_WAKE: begin
                if (wake_det) begin
                    state_d = LK_ACTIVE;
                end else if (cnt_q >= lim_q) begin
                    state_d = LK_ACTIVE;
                    tmo_d   = 1'b1;
                end
            end
            default: state_d = LK_OFF;
        endcase
        // d3 or empty port is off
        if (d3 || !en || !present) begin
            state_d = LK_OFF;
            cw_d    = 1'b0;
            tmo_d   = 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= LK_OFF;
            lim_q   <= '0;
            pp_q    <= 1'b0;
            sp_q    <= 1'b0;
        end else begin
            state_q <= state_d;
            lim_q   <= lim_d;
            pp_q    <= part_req;
            sp_q    <= slum_req;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= '0;
        end else if (state_q == LK_WAKE) begin
            cnt_q <= cnt_q + 24'h000001;
        end else begin
            cnt_q <= 24'h000001;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ack_q     <= 1'b0;
            comwake_q <= 1'b0;
            devslp_q  <= 1'b0;
            gate_q    <= 1'b0;
            pwrdn_q   <= 1'b1;
            tmo_q     <= 1'b0;
        end else begin
            ack_q     <= ack_d;
            comwake_q <= cw_d;
            tmo_q     <= tmo_d;
            // sleep follows slumber, drops on wake
            devslp_q  <= (state_d == LK_DEVSLP);
            gate_q    <= gate_en && (state_d == LK_PARTIAL || state_d == LK_SLUMBER);
            pwrdn_q   <= (state_d == LK_OFF || state_d == LK_DEVSLP);
        end
    end
endmodule
`default_nettype wire

//--- core/slpm_sync.sv
/*
 * Two-flop synchroniser for pin inputs.
 * Assumes inputs are quasi-static levels from outside the hclk domain.
 */
`timescale 1ns/1ps
`default_nettype none
module slpm_sync #(
    parameter int W = 13
) (
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule
`default_nettype wire

//--- core/slpm_top.sv
/*
 * Link power manager top: AHB-Lite register slave, D3 handling,
 * presence reporting, activity indicator and three port link machines.
 * Assumes one hclk domain; device pins are asynchronous and synchronised.
 */
// Chosen here: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "slpm_consts.svh"
module slpm_top
    import slpm_pkg::*;
#(
    parameter int SLUMBER_EXIT_CYC = `SLPM_SLUMBER_EXIT_MS * (`SLPM_CLK_HZ / 1000),
    parameter int DEVSLP_EXIT_CYC  = `SLPM_DEVSLP_EXIT_MS * (`SLPM_CLK_HZ / 1000)
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output var  logic [31:0] hrdata,
    output var  logic        hreadyout,
    output var  logic        hresp,
    input  wire logic [2:0]  port_busy_flag,
    input  wire logic [2:0]  port_op_req,
    input  wire logic        ctrl_irq_pending,
    input  wire logic [2:0]  dev_partial_req,
    input  wire logic [2:0]  dev_slumber_req,
    input  wire logic [2:0]  dev_comwake_det,
    input  wire logic [2:0]  dev_present_det,
    input  wire logic        drive_activity_indicator_n_in,
    output var  logic        drive_activity_indicator_n_out,
    output var  logic        drive_activity_indicator_n_oe,
    output var  logic [2:0]  link_pm_ack,
    output var  logic [2:0]  link_comwake,
    output var  logic [2:0]  dev_sleep,
    output var  logic [2:0]  phy_gate,
    output var  logic [2:0]  phy_power_down,
    output var  logic        irq_out
);
    localparam int          NP         = `SLPM_NPORT;
    localparam int          CYC_PER_MS = `SLPM_CLK_HZ / 1000;
    localparam logic [23:0] SLUM_LIM   = 24'(SLUMBER_EXIT_CYC);
    localparam logic [23:0] DSLP_LIM   = 24'(DEVSLP_EXIT_CYC);

    function automatic slpm_reg_t reg_dec(input logic [11:0] a);
        if (a == `SLPM_ADDR_PCS) begin
            return RS_PCS;
        end else if (a == `SLPM_ADDR_PMCSR) begin
            return RS_PMCSR;
        end else if (a == `SLPM_ADDR_LPCTL) begin
            return RS_LPCTL;
        end else if (a == `SLPM_ADDR_LSTAT) begin
            return RS_LSTAT;
        end else if (a == `SLPM_ADDR_DETO) begin
            return RS_DETO;
        end else if (a == `SLPM_ADDR_PHYGATE) begin
            return RS_PHYGATE;
        end else begin
            return RS_NONE;
        end
    endfunction

    logic [12:0] pin_s;
    logic [2:0]  part_s, slum_s, wake_s, pres_s;
    logic        led_s;

    slpm_sync #(
        .W (13)
    ) u_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .d       ({drive_activity_indicator_n_in, dev_present_det,
                   dev_comwake_det, dev_slumber_req, dev_partial_req}),
        .q       (pin_s)
    );

    assign part_s = pin_s[2:0];
    assign slum_s = pin_s[5:3];
    assign wake_s = pin_s[8:6];
    assign pres_s = pin_s[11:9];
    assign led_s  = pin_s[12];

    // registers
    logic [2:0]  port_enable_bit_q;
    logic [1:0]  pwr_q;
    logic        lp_en_q;
    logic [2:0]  devslp_en_q;
    logic [2:0]  tmo_sticky_q;
    logic        abort_q;
    logic [7:0]  deto_q;
    logic [2:0]  phy_dynamic_gating_enable_q;
    logic        d3;

    assign d3 = (pwr_q == `SLPM_PWR_D3);

    // bus phases
    logic        wr_pend_q, rd_pend_q;
    logic [11:0] addr_q;
    logic        addr_ph;
    slpm_reg_t   wsel, rsel;
    logic        wr_ok, wr_blk, rd_blk;

    assign addr_ph = hsel && hready && htrans == `SLPM_HTRANS_NSEQ;
    assign wsel    = reg_dec(addr_q);
    assign rsel    = reg_dec(addr_q);
    // only power state reachable in d3
    assign wr_blk  = wr_pend_q && d3 && wsel != RS_PMCSR;
    assign rd_blk  = rd_pend_q && d3 && rsel != RS_PMCSR;
    assign wr_ok   = wr_pend_q && !wr_blk;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q    <= '0;
        end else begin
            wr_pend_q <= addr_ph && hwrite;
            rd_pend_q <= addr_ph && !hwrite;
            if (addr_ph) begin
                addr_q <= haddr[11:0];
            end
        end
    end

    // reads take one wait state so a preceding write is visible
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= !(addr_ph && !hwrite);
            hresp     <= 1'b0;
        end
    end

    slpm_link_t  st   [NP];
    logic [2:0]  ack_v, cw_v, ds_v, gt_v, pd_v, tmo_v;
    logic [23:0] ds_lim;

    assign ds_lim = (deto_q != 8'h00) ? 24'(deto_q * CYC_PER_MS) : DSLP_LIM;

    logic [31:0] rd_val;
    always_comb begin
        rd_val = '0;
        if (rsel == RS_PCS) begin
            rd_val[`SLPM_PCS_EN_LSB +: NP] = port_enable_bit_q;
            rd_val[`SLPM_PCS_PR_LSB +: NP] = d3 ? 3'h0 : (pres_s & port_enable_bit_q);
        end else if (rsel == RS_PMCSR) begin
            rd_val[1:0] = pwr_q;
        end else if (rsel == RS_LPCTL) begin
            rd_val[`SLPM_LP_EN_BIT]         = lp_en_q;
            rd_val[`SLPM_LP_DS_LSB +: NP]   = devslp_en_q;
        end else if (rsel == RS_LSTAT) begin
            rd_val[2:0]                     = st[0];
            rd_val[5:3]                     = st[1];
            rd_val[8:6]                     = st[2];
            rd_val[`SLPM_LS_TMO_LSB +: NP]  = tmo_sticky_q;
            rd_val[`SLPM_LS_ABT_BIT]        = abort_q;
            rd_val[`SLPM_LS_LED_BIT]        = led_s;
        end else if (rsel == RS_DETO) begin
            rd_val[7:0] = deto_q;
        end else if (rsel == RS_PHYGATE) begin
            rd_val[NP-1:0] = phy_dynamic_gating_enable_q;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= '0;
        end else if (rd_pend_q) begin
            hrdata <= rd_blk ? 32'h00000000 : rd_val;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            port_enable_bit_q <= `SLPM_PCS_RST;
        end else if (wr_ok && wsel == RS_PCS) begin
            port_enable_bit_q <= hwdata[`SLPM_PCS_EN_LSB +: NP];
        end
    end

    // power state, no reset on exit
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pwr_q <= `SLPM_PWR_D0;
        end else if (wr_ok && wsel == RS_PMCSR) begin
            pwr_q <= hwdata[1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lp_en_q     <= 1'b0;
            devslp_en_q <= 3'h0;
        end else if (wr_ok && wsel == RS_LPCTL) begin
            lp_en_q     <= hwdata[`SLPM_LP_EN_BIT];
            devslp_en_q <= hwdata[`SLPM_LP_DS_LSB +: NP];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            deto_q <= `SLPM_DETO_RST;
        end else if (wr_ok && wsel == RS_DETO) begin
            deto_q <= hwdata[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phy_dynamic_gating_enable_q <= 3'h0;
        end else if (wr_ok && wsel == RS_PHYGATE) begin
            phy_dynamic_gating_enable_q <= hwdata[NP-1:0];
        end
    end

    // sticky status, set wins over write-one-to-clear
    logic [2:0] tmo_clr;
    logic       abt_clr;
    assign tmo_clr = (wr_ok && wsel == RS_LSTAT) ? hwdata[`SLPM_LS_TMO_LSB +: NP] : 3'h0;
    assign abt_clr = wr_ok && wsel == RS_LSTAT && hwdata[`SLPM_LS_ABT_BIT];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tmo_sticky_q <= 3'h0;
        end else begin
            tmo_sticky_q <= (tmo_sticky_q & ~tmo_clr) | tmo_v;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            abort_q <= 1'b0;
        end else begin
            abort_q <= (abort_q && !abt_clr) || wr_blk || rd_blk;
        end
    end

    genvar p;
    generate
        for (p = 0; p < NP; p++) begin : g_port
            slpm_port_link u_link (
                .hclk        (hclk),
                .hresetn     (hresetn),
                .en          (port_enable_bit_q[p]),
                .present     (pres_s[p]),
                .d3          (d3),
                .lp_en       (lp_en_q),
                .devslp_en   (devslp_en_q[p]),
                .gate_en     (phy_dynamic_gating_enable_q[p]),
                .op_req      (port_op_req[p]),
                .part_req    (part_s[p]),
                .slum_req    (slum_s[p]),
                .wake_det    (wake_s[p]),
                .slumber_lim (SLUM_LIM),
                .devslp_lim  (ds_lim),
                .state_q     (st[p]),
                .ack_q       (ack_v[p]),
                .comwake_q   (cw_v[p]),
                .devslp_q    (ds_v[p]),
                .gate_q      (gt_v[p]),
                .pwrdn_q     (pd_v[p]),
                .tmo_q       (tmo_v[p])
            );
        end
    endgenerate

    assign link_pm_ack    = ack_v;
    assign link_comwake   = cw_v;
    assign dev_sleep      = ds_v;
    assign phy_gate       = gt_v;
    assign phy_power_down = pd_v;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            drive_activity_indicator_n_out <= 1'b0;
            drive_activity_indicator_n_oe  <= 1'b0;
        end else begin
            drive_activity_indicator_n_out <= 1'b0;
            drive_activity_indicator_n_oe  <= |port_busy_flag;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= ctrl_irq_pending && !d3;
        end
    end
endmodule
`default_nettype wire

//--- testbench/slpm_dev_model.sv
/* Model of the attached storage devices: power requests and COMWAKE replies.
   Assumes the bench steers the requests; one hclk domain. */
`timescale 1ns/1ps
`default_nettype none
module slpm_dev_model (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic [2:0] part_cmd,
    input  wire logic [2:0] slum_cmd,
    input  wire logic [2:0] slow,
    input  wire logic [2:0] link_comwake,
    input  wire logic [2:0] dev_sleep,
    output var  logic [2:0] dev_partial_req,
    output var  logic [2:0] dev_slumber_req,
    output var  logic [2:0] dev_comwake_det
);
    logic [2:0] slp_q;
    int         cnt_q [3];
    assign dev_partial_req = part_cmd;
    assign dev_slumber_req = slum_cmd;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            slp_q <= 3'h0;
            dev_comwake_det <= 3'h0;
            cnt_q <= '{0, 0, 0};
        end else begin
            slp_q <= dev_sleep;
            for (int i = 0; i < 3; i++) begin
                if ((link_comwake[i] || (slp_q[i] && !dev_sleep[i])) && !slow[i])
                    cnt_q[i] <= 6;
                else if (cnt_q[i] > 0)
                    cnt_q[i] <= cnt_q[i] - 1;
                dev_comwake_det[i] <= cnt_q[i] > 0 && cnt_q[i] < 4;
            end
        end
    end
endmodule
`default_nettype wire

//--- testbench/slpm_top_asserts.sv
/* Checker of the link power manager top ports.
   Assumes binding into slpm_top; one hclk domain. */
`timescale 1ns/1ps
`default_nettype none
module slpm_top_asserts #(
    parameter int SLUMBER_EXIT_CYC = 20,
    parameter int DEVSLP_EXIT_CYC  = 40
) (
    input wire logic       hclk,
    input wire logic       hresetn,
    input wire logic       hsel,
    input wire logic [1:0] htrans,
    input wire logic       hwrite,
    input wire logic       hready,
    input wire logic       hreadyout,
    input wire logic       hresp,
    input wire logic [2:0] port_busy_flag,
    input wire logic [2:0] port_op_req,
    input wire logic       ctrl_irq_pending,
    input wire logic [2:0] dev_partial_req,
    input wire logic [2:0] dev_slumber_req,
    input wire logic       drive_activity_indicator_n_out,
    input wire logic       drive_activity_indicator_n_oe,
    input wire logic [2:0] link_pm_ack,
    input wire logic [2:0] link_comwake,
    input wire logic [2:0] dev_sleep,
    input wire logic [2:0] phy_power_down,
    input wire logic       irq_out
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_ack_has_req: assert property (link_pm_ack[0] |->
        $past(dev_partial_req[0], 2) || $past(dev_slumber_req[0], 2)) else $error("ack without request");
    a_comwake_pulse: assert property (link_comwake[0] |=> !link_comwake[0])
        else $error("comwake longer than one cycle");
    a_led_on: assert property (|port_busy_flag |=> drive_activity_indicator_n_oe && !drive_activity_indicator_n_out)
        else $error("indicator not pulled low");
    a_led_off: assert property (!(|port_busy_flag) |=> !drive_activity_indicator_n_oe)
        else $error("indicator held low while idle");
    a_irq_cause: assert property (irq_out |-> $past(ctrl_irq_pending))
        else $error("interrupt without pending status");
    a_sleep_powered: assert property (dev_sleep[0] |-> phy_power_down[0])
        else $error("phy powered in device sleep");
    a_sleep_entry: assert property ($rose(dev_sleep[0]) |-> !$past(port_op_req[0]))
        else $error("device sleep entered while host needs link");
    a_sleep_exit: assert property ($fell(dev_sleep[0]) |-> !link_comwake[0])
        else $error("host comwake while leaving device sleep");
    a_read_wait: assert property (hsel && hready && htrans == 2'h2 && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    a_write_zero: assert property (hsel && hready && htrans == 2'h2 && hwrite |=> hreadyout)
        else $error("write stalled");
    a_resp_okay: assert property (!hresp)
        else $error("error response");
    c_ack: cover property (link_pm_ack[1]);
    c_sleep: cover property ($rose(dev_sleep[0]));
    c_comwake: cover property (link_comwake[2]);
endmodule
bind slpm_top slpm_top_asserts #(
    .SLUMBER_EXIT_CYC(SLUMBER_EXIT_CYC), .DEVSLP_EXIT_CYC(DEVSLP_EXIT_CYC)
) slpm_top_asserts_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .port_busy_flag(port_busy_flag),
    .port_op_req(port_op_req), .ctrl_irq_pending(ctrl_irq_pending), .dev_partial_req(dev_partial_req),
    .dev_slumber_req(dev_slumber_req), .drive_activity_indicator_n_out(drive_activity_indicator_n_out),
    .drive_activity_indicator_n_oe(drive_activity_indicator_n_oe), .link_pm_ack(link_pm_ack),
    .link_comwake(link_comwake), .dev_sleep(dev_sleep), .phy_power_down(phy_power_down), .irq_out(irq_out)
);
`default_nettype wire

//--- testbench/tb.sv
/* Bench of the link power manager: register table, then link and D3 cases.
   Assumes the device model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module tb;
    typedef struct packed { logic [11:0] a; logic [31:0] w; logic [31:0] e; } slpm_row_t;
    logic        hclk, hresetn, hsel, hwrite, irq_p, hreadyout, hresp, led_out, led_oe, irq_out;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [2:0]  busy, op_req, present, part_cmd, slum_cmd, slow;
    logic [2:0]  preq, sreq, cwdet, ack, cw, dslp, gate, pdn;
    int          error_cnt = 0, cmp_count = 0;
    wire         led_pin = led_oe ? 1'b0 : 1'b1;
    wire  [8:0]  ev = {dslp, cw, ack};
    slpm_row_t   rows [9] = '{'{12'h000, 32'h0, 32'h0}, '{12'h000, 32'hFFFFFFFF, 32'h707},
        '{12'h004, 32'h0, 32'h0}, '{12'h008, 32'hFFFFFFFF, 32'hF}, '{12'h008, 32'h2, 32'h2},
        '{12'h010, 32'h1FF, 32'hFF}, '{12'h010, 32'h100, 32'h0}, '{12'h050, 32'hFF, 32'h7},
        '{12'h040, 32'hFFFFFFFF, 32'h0}};
    slpm_top #(.SLUMBER_EXIT_CYC(20), .DEVSLP_EXIT_CYC(40)) slpm_top_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .port_busy_flag(busy), .port_op_req(op_req), .ctrl_irq_pending(irq_p),
        .dev_partial_req(preq), .dev_slumber_req(sreq), .dev_comwake_det(cwdet), .dev_present_det(present),
        .drive_activity_indicator_n_in(led_pin), .drive_activity_indicator_n_out(led_out),
        .drive_activity_indicator_n_oe(led_oe), .link_pm_ack(ack), .link_comwake(cw), .dev_sleep(dslp),
        .phy_gate(gate), .phy_power_down(pdn), .irq_out(irq_out));
    slpm_dev_model slpm_dev_model_inst (.hclk(hclk), .hresetn(hresetn), .part_cmd(part_cmd),
        .slum_cmd(slum_cmd), .slow(slow), .link_comwake(cw), .dev_sleep(dslp),
        .dev_partial_req(preq), .dev_slumber_req(sreq), .dev_comwake_det(cwdet));
    always #50 hclk = ~hclk;
    task automatic results();
        if (error_cnt == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    // one AHB single transfer, waits on hready
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        hsel <= 1'b1; haddr <= {20'h0, a}; htrans <= 2'h2; hwrite <= w;
        do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 40);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
        do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 40);
        rd = hrdata;
        if (n >= 40) begin error_cnt++; results(); end
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rd & m, e);
    endtask
    task automatic wait_ev(input int b, input logic v);
        int n;
        n = 0;
        while (ev[b] !== v && n < 60) begin @(posedge hclk); n++; end
        if (n >= 60) begin error_cnt++; results(); end
    endtask
    initial begin
        {hclk, hresetn, hsel, hwrite, irq_p} = 5'h0;
        htrans = 2'h0; haddr = 32'h0; hwdata = 32'h0; present = 3'h7;
        {busy, op_req, part_cmd, slum_cmd, slow} = 15'h0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk(pdn, 3'h7);
        foreach (rows[i]) begin
            bus(1'b1, rows[i].a, rows[i].w);
            rdchk(rows[i].a, 32'hFFFFFFFF, rows[i].e);
        end
        busy <= 3'h4;
        repeat (3) @(posedge hclk);
        chk({led_oe, led_out}, 2'h2);
        rdchk(12'h00C, 32'h4000, 32'h0);
        busy <= 3'h0;
        repeat (2) @(posedge hclk);
        chk(led_oe, 1'b0);
        // slumber then device sleep on port 0
        slum_cmd <= 3'h1;
        wait_ev(0, 1'b1);
        slum_cmd <= 3'h0;
        wait_ev(6, 1'b1);
        chk(pdn[0], 1'b1);
        op_req <= 3'h1;
        wait_ev(6, 1'b0);
        chk(cw[0], 1'b0);
        repeat (12) @(posedge hclk);
        op_req <= 3'h0;
        rdchk(12'h00C, 32'h5C07, 32'h4001);
        // partial on port 1, host wake
        part_cmd <= 3'h2;
        wait_ev(1, 1'b1);
        part_cmd <= 3'h0;
        rdchk(12'h00C, 32'h38, 32'h18);
        chk(gate[1], 1'b1);
        op_req <= 3'h2;
        wait_ev(4, 1'b1);
        repeat (4) @(posedge hclk);
        op_req <= 3'h0;
        rdchk(12'h00C, 32'h1C38, 32'h808);
        bus(1'b1, 12'h00C, 32'h1C00);
        rdchk(12'h00C, 32'h1C38, 32'h8);
        // slumber on port 2, device never answers
        slow <= 3'h4;
        slum_cmd <= 3'h4;
        wait_ev(2, 1'b1);
        slum_cmd <= 3'h0;
        rdchk(12'h00C, 32'h1C0, 32'h80);
        op_req <= 3'h4;
        wait_ev(5, 1'b1);
        repeat (30) @(posedge hclk);
        op_req <= 3'h0;
        rdchk(12'h00C, 32'h1DC0, 32'h1040);
        bus(1'b1, 12'h00C, 32'h1000);
        rdchk(12'h00C, 32'h1000, 32'h0);
        // controller into D3 and back
        irq_p <= 1'b1;
        bus(1'b1, 12'h004, 32'h3);
        repeat (3) @(posedge hclk);
        chk({irq_out, pdn}, 4'h7);
        bus(1'b1, 12'h000, 32'h0);
        rdchk(12'h000, 32'hFFFFFFFF, 32'h0);
        present <= 3'h5;
        bus(1'b1, 12'h004, 32'h0);
        rdchk(12'h000, 32'hFFFFFFFF, 32'h507);
        rdchk(12'h00C, 32'h2000, 32'h2000);
        chk(irq_out, 1'b1);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        chk({hreadyout, pdn, dslp}, 7'h78);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdchk(12'h000, 32'hFFFFFFFF, 32'h0);
        results();
    end
endmodule
`default_nettype wire
